//--- ragc_pkg.sv
// constants, tables and types for the record-path automatic gain control
package ragc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  localparam logic [6:0] RIGHT_ATTACK_EXTENDED_OFS = 7'h67;
  localparam logic [6:0] RIGHT_DECAY_EXTENDED_OFS  = 7'h68;
  localparam logic [6:0] LEFT_ATTACK_EXTENDED_OFS  = 7'h69;
  localparam logic [6:0] LEFT_DECAY_EXTENDED_OFS   = 7'h6A;

  localparam logic [7:0] ATTACK_EXTENDED_RST = 8'h00;
  localparam logic [7:0] DECAY_EXTENDED_RST  = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED      = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // sample path and gain code (one code step is 0.5 dB)
  localparam int unsigned SAMPLE_W  = 16;
  localparam int unsigned GAIN_W    = 7;
  localparam logic [6:0]  GAIN_ZERO = 7'h00;
  localparam logic [6:0]  GAIN_MAX  = 7'h77;
  localparam logic [15:0] FULL_POS  = 16'h7FFF;
  localparam logic [15:0] FULL_NEG  = 16'h8000;

  // running mean: 16 integer bits, 8 fraction bits, weight 1/64 per sample
  localparam int unsigned AVG_FRAC  = 8;
  localparam int unsigned AVG_W     = SAMPLE_W + AVG_FRAC;
  localparam int unsigned AVG_SHIFT = 6;

  // target levels -5.5, -8, -10, -12, -14, -17, -20, -24 dBFS as mean magnitude
  localparam logic [15:0] TARGET_LVL [8] = '{
    16'h43EF, 16'h32F5, 16'h287A, 16'h2027, 16'h198A, 16'h121F, 16'h0CCD, 16'h0814
  };

  // noise threshold: -30 dBFS at code 0, 6 dB lower per code, -90 dBFS at code 10
  localparam logic [15:0] NOISE_THR_BASE = 16'h040C;
  localparam logic [3:0]  NOISE_SEL_MAX  = 4'hA;

  ////////////////////////////////////////////////////////////////////////////
  // timing, counted in ADC output samples at the programmed reference rate
  localparam longint FSREF_HZ            = 48000;
  localparam longint ATTACK_MIN_US       = 7000;
  localparam longint ATTACK_MAX_US       = 1408000;
  localparam longint DECAY_MIN_MS        = 50;
  localparam longint DECAY_LIMIT_RATIO1_MS = 4000;
  localparam int unsigned TMR_W          = 18;
  localparam longint ATT_MIN_L = (ATTACK_MIN_US * FSREF_HZ + 999999) / 1000000;
  localparam longint ATT_MAX_L = (ATTACK_MAX_US * FSREF_HZ) / 1000000;
  localparam longint DEC_MIN_L = (DECAY_MIN_MS * FSREF_HZ + 999) / 1000;
  localparam longint DEC_LIM_L = (DECAY_LIMIT_RATIO1_MS * FSREF_HZ) / 1000;
  localparam logic [17:0] ATT_MIN_SMP = 18'(ATT_MIN_L);
  localparam logic [17:0] ATT_INC_SMP = 18'((ATT_MAX_L - ATT_MIN_L) / 255);
  localparam logic [17:0] DEC_MIN_SMP = 18'(DEC_MIN_L);
  localparam logic [17:0] DEC_INC_SMP = 18'((DEC_LIM_L - DEC_MIN_L) / 255);
  localparam logic [17:0] TMR_LIMIT   = 18'(DEC_LIM_L);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [0:0] {
    GATE_OPEN   = 1'b0,
    GATE_CLOSED = 1'b1
  } ragc_gate_e;

endpackage : ragc_pkg

//--- ragc_record_agc.sv
// stereo record-path automatic gain control, one controller per adc channel
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - left and right each own a full controller and settings; nothing shared.
// - amplitude is a running mean of sample magnitude, never a peak.
// - with control off, amplifier gain follows the manual gain input.
// - enabled, gain falls when mean exceeds target and rises below target.
// - eight target levels from -5.5 dBFS to -24 dBFS.
// - attack step interval programmable, 7 ms to 1408 ms.
// - extended attack registers: right at 0x67, left at 0x69.
// - decay step interval programmable, 0.05 s to 4 s.
// - extended decay registers: right at 0x68, left at 0x6A.
// - decay uses a fixed-length sample counter, so limit scales with rate divider.
// - below noise threshold, gain ramps to 0 dB one step per sample; flag set.
// - while gated, gain stays 0 dB until mean rises above threshold raised by hysteresis.
// - noise threshold -30 to -90 dBFS, and the gate can be switched off.
// - gate decision has programmable debounce and hysteresis.
// - with control on, gain never rises above a programmable ceiling, 0 to 59.5 dB.
// - timing counted from the reference sample rate; single-rate mode only.
// - each gain move is one 0.5 dB step per one or two samples.
// - gain spans 0 to 59.5 dB and the amplifier is muted after reset.
module ragc_record_agc (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // decimated adc samples, one strobe per output sample
  input  wire logic [15:0] adc_sample_left_i,
  input  wire logic        adc_sample_valid_left_i,
  input  wire logic [15:0] adc_sample_right_i,
  input  wire logic        adc_sample_valid_right_i,
  // left channel settings
  input  wire logic        agc_enable_left_i,
  input  wire logic [2:0]  target_sel_left_i,
  input  wire logic        noise_gate_enable_left_i,
  input  wire logic [3:0]  noise_thr_sel_left_i,
  input  wire logic [1:0]  hysteresis_sel_left_i,
  input  wire logic [7:0]  debounce_len_left_i,
  input  wire logic [6:0]  max_gain_left_i,
  input  wire logic [6:0]  manual_gain_left_i,
  input  wire logic        mute_left_i,
  input  wire logic        step_slow_left_i,
  // right channel settings
  input  wire logic        agc_enable_right_i,
  input  wire logic [2:0]  target_sel_right_i,
  input  wire logic        noise_gate_enable_right_i,
  input  wire logic [3:0]  noise_thr_sel_right_i,
  input  wire logic [1:0]  hysteresis_sel_right_i,
  input  wire logic [7:0]  debounce_len_right_i,
  input  wire logic [6:0]  max_gain_right_i,
  input  wire logic [6:0]  manual_gain_right_i,
  input  wire logic        mute_right_i,
  input  wire logic        step_slow_right_i,
  // amplifier control and status
  output logic      [6:0]  pga_gain_left_o,
  output logic             pga_mute_left_o,
  output logic             noise_gate_flag_left_o,
  output logic             saturation_flag_left_o,
  output logic      [6:0]  pga_gain_right_o,
  output logic             pga_mute_right_o,
  output logic             noise_gate_flag_right_o,
  output logic             saturation_flag_right_o
);

  ////////////////////////////////////////////////////////////////////////////
  // channel index 0 is left, 1 is right
  logic [15:0] smp_w      [2];
  logic        smp_vld_w  [2];
  logic        agc_en_w   [2];
  logic [2:0]  tgt_sel_w  [2];
  logic        ng_en_w    [2];
  logic [3:0]  ng_sel_w   [2];
  logic [1:0]  hyst_sel_w [2];
  logic [7:0]  deb_len_w  [2];
  logic [6:0]  max_gain_w [2];
  logic [6:0]  man_gain_w [2];
  logic        mute_w     [2];
  logic        slow_w     [2];
  logic [6:0]  gain_w     [2];
  logic        pmute_w    [2];
  logic        gate_w     [2];
  logic        sat_w      [2];

  assign smp_w[0]      = adc_sample_left_i;
  assign smp_w[1]      = adc_sample_right_i;
  assign smp_vld_w[0]  = adc_sample_valid_left_i;
  assign smp_vld_w[1]  = adc_sample_valid_right_i;
  assign agc_en_w[0]   = agc_enable_left_i;
  assign agc_en_w[1]   = agc_enable_right_i;
  assign tgt_sel_w[0]  = target_sel_left_i;
  assign tgt_sel_w[1]  = target_sel_right_i;
  assign ng_en_w[0]    = noise_gate_enable_left_i;
  assign ng_en_w[1]    = noise_gate_enable_right_i;
  assign ng_sel_w[0]   = noise_thr_sel_left_i;
  assign ng_sel_w[1]   = noise_thr_sel_right_i;
  assign hyst_sel_w[0] = hysteresis_sel_left_i;
  assign hyst_sel_w[1] = hysteresis_sel_right_i;
  assign deb_len_w[0]  = debounce_len_left_i;
  assign deb_len_w[1]  = debounce_len_right_i;
  assign max_gain_w[0] = max_gain_left_i;
  assign max_gain_w[1] = max_gain_right_i;
  assign man_gain_w[0] = manual_gain_left_i;
  assign man_gain_w[1] = manual_gain_right_i;
  assign mute_w[0]     = mute_left_i;
  assign mute_w[1]     = mute_right_i;
  assign slow_w[0]     = step_slow_left_i;
  assign slow_w[1]     = step_slow_right_i;

  assign pga_gain_left_o         = gain_w[0];
  assign pga_gain_right_o        = gain_w[1];
  assign pga_mute_left_o         = pmute_w[0];
  assign pga_mute_right_o        = pmute_w[1];
  assign noise_gate_flag_left_o  = gate_w[0];
  assign noise_gate_flag_right_o = gate_w[1];
  assign saturation_flag_left_o  = sat_w[0];
  assign saturation_flag_right_o = sat_w[1];

  ////////////////////////////////////////////////////////////////////////////
  // extended attack and decay registers
  logic [7:0] att_ff [2];
  logic [7:0] dec_ff [2];
  logic [7:0] rdata_ff;
  logic [6:0] att_addr_w [2];
  logic [6:0] dec_addr_w [2];
  logic [7:0] nxt_rdata;

  assign att_addr_w[0] = ragc_pkg::LEFT_ATTACK_EXTENDED_OFS;
  assign att_addr_w[1] = ragc_pkg::RIGHT_ATTACK_EXTENDED_OFS;
  assign dec_addr_w[0] = ragc_pkg::LEFT_DECAY_EXTENDED_OFS;
  assign dec_addr_w[1] = ragc_pkg::RIGHT_DECAY_EXTENDED_OFS;

  // a read in the same cycle as a write returns the old value
  assign nxt_rdata =
    (reg_addr_i == att_addr_w[0]) ? att_ff[0] :
    (reg_addr_i == att_addr_w[1]) ? att_ff[1] :
    (reg_addr_i == dec_addr_w[0]) ? dec_ff[0] :
    (reg_addr_i == dec_addr_w[1]) ? dec_ff[1] : ragc_pkg::RDATA_UNMAPPED;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= ragc_pkg::RDATA_UNMAPPED;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // one independent controller per channel
  genvar ch;
  for (ch = 0; ch < 2; ch++) begin : g_chan
    logic [23:0] avg_ff;
    logic [6:0]  gain_ff;
    logic [17:0] tmr_ff;
    logic [7:0]  deb_ff;
    logic        phase_ff;
    logic        sat_ff;
    logic        mute_ff;
    ragc_pkg::ragc_gate_e gate_ff;

    logic               att_wr_w;
    logic               dec_wr_w;
    logic [15:0]        mag_w;
    logic signed [24:0] diff_w;
    logic [23:0]        nxt_avg;
    logic [15:0]        avg_int_w;
    logic [15:0]        tgt_w;
    logic [3:0]         ng_cl_w;
    logic [15:0]        thr_w;
    logic [17:0]        rel_w;
    logic               below_w;
    logic               above_w;
    logic               gated_w;
    logic               flip_cond_w;
    logic               deb_done_w;
    logic [6:0]         max_cl_w;
    logic [6:0]         man_cl_w;
    logic               loud_w;
    logic               quiet_w;
    logic               ceil_dn_w;
    logic [17:0]        att_int_w;
    logic [17:0]        dec_int_w;
    logic               pace_w;
    logic               step_dn_w;
    logic               step_up_w;
    logic               tmr_run_w;
    logic [6:0]         nxt_gain;
    logic [17:0]        nxt_tmr;
    logic [7:0]         nxt_deb;
    ragc_pkg::ragc_gate_e nxt_gate;

    // register writes
    assign att_wr_w = reg_wr_i & (reg_addr_i == att_addr_w[ch]);
    assign dec_wr_w = reg_wr_i & (reg_addr_i == dec_addr_w[ch]);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        att_ff[ch] <= ragc_pkg::ATTACK_EXTENDED_RST;
        dec_ff[ch] <= ragc_pkg::DECAY_EXTENDED_RST;
      end else begin
        if (att_wr_w) att_ff[ch] <= reg_wdata_i;
        if (dec_wr_w) dec_ff[ch] <= reg_wdata_i;
      end
    end

    // mean of magnitude; -full scale maps to 0x8000 which still fits
    assign mag_w     = smp_w[ch][15] ? 16'(~smp_w[ch] + 16'h0001) : smp_w[ch];
    assign diff_w    = $signed({1'b0, mag_w, 8'h00}) - $signed({1'b0, avg_ff});
    assign nxt_avg   = 24'($signed({1'b0, avg_ff}) + (diff_w >>> ragc_pkg::AVG_SHIFT));
    assign avg_int_w = avg_ff[23:8];
    assign tgt_w     = ragc_pkg::TARGET_LVL[tgt_sel_w[ch]];

    // noise gate: enter below threshold, leave above threshold raised by hysteresis
    assign ng_cl_w     = (ng_sel_w[ch] > ragc_pkg::NOISE_SEL_MAX) ? ragc_pkg::NOISE_SEL_MAX : ng_sel_w[ch];
    assign thr_w       = ragc_pkg::NOISE_THR_BASE >> ng_cl_w;
    assign rel_w       = {2'b00, thr_w} << hyst_sel_w[ch];
    assign below_w     = avg_int_w < thr_w;
    assign above_w     = {2'b00, avg_int_w} > rel_w;
    assign gated_w     = (gate_ff == ragc_pkg::GATE_CLOSED);
    assign flip_cond_w = gated_w ? above_w : below_w;
    assign deb_done_w  = flip_cond_w & (deb_ff >= deb_len_w[ch]);

    // any lapse of the condition restarts the debounce count
    always_comb begin
      nxt_gate = gate_ff;
      nxt_deb  = 8'h00;
      if (!ng_en_w[ch] || !agc_en_w[ch]) begin
        nxt_gate = ragc_pkg::GATE_OPEN;
      end else if (deb_done_w) begin
        nxt_gate = gated_w ? ragc_pkg::GATE_OPEN : ragc_pkg::GATE_CLOSED;
      end else if (flip_cond_w) begin
        nxt_deb = deb_ff + 8'h01;
      end
    end

    // gain steering
    assign max_cl_w  = (max_gain_w[ch] > ragc_pkg::GAIN_MAX) ? ragc_pkg::GAIN_MAX : max_gain_w[ch];
    assign man_cl_w  = (man_gain_w[ch] > ragc_pkg::GAIN_MAX) ? ragc_pkg::GAIN_MAX : man_gain_w[ch];
    assign loud_w    = avg_int_w > tgt_w;
    assign quiet_w   = avg_int_w < tgt_w;
    assign ceil_dn_w = gain_ff > max_cl_w;
    assign att_int_w = 18'(ragc_pkg::ATT_MIN_SMP + att_ff[ch] * ragc_pkg::ATT_INC_SMP);
    assign dec_int_w = 18'(ragc_pkg::DEC_MIN_SMP + dec_ff[ch] * ragc_pkg::DEC_INC_SMP);
    assign pace_w    = !slow_w[ch] | phase_ff;

    // gated ramp runs every sample; other moves obey the soft-step pace
    assign step_dn_w = (agc_en_w[ch] && gated_w) ? (gain_ff != ragc_pkg::GAIN_ZERO) :
                       pace_w & (agc_en_w[ch]
                         ? (ceil_dn_w | (loud_w & (gain_ff != ragc_pkg::GAIN_ZERO)
                                         & (tmr_ff >= att_int_w)))
                         : (gain_ff > man_cl_w));
    assign step_up_w = !(agc_en_w[ch] && gated_w) & !step_dn_w & pace_w & (agc_en_w[ch]
                         ? (quiet_w & (gain_ff < max_cl_w) & (tmr_ff >= dec_int_w))
                         : (gain_ff < man_cl_w));

    assign nxt_gain  = step_dn_w ? gain_ff - 7'h01 :
                       step_up_w ? gain_ff + 7'h01 : gain_ff;
    // fixed-length counter of output samples: its limit in seconds scales with the divider
    assign tmr_run_w = agc_en_w[ch] & !gated_w & (loud_w | quiet_w);
    assign nxt_tmr   = (step_dn_w | step_up_w | !tmr_run_w) ? 18'h00000 :
                       (tmr_ff >= ragc_pkg::TMR_LIMIT) ? ragc_pkg::TMR_LIMIT : tmr_ff + 18'h00001;

    // everything advances on the sample strobe, an enable once per output sample on the reference clock
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        avg_ff   <= 24'h000000;
        gain_ff  <= ragc_pkg::GAIN_ZERO;
        tmr_ff   <= 18'h00000;
        deb_ff   <= 8'h00;
        phase_ff <= 1'b0;
        sat_ff   <= 1'b0;
        mute_ff  <= 1'b1;
        gate_ff  <= ragc_pkg::GATE_OPEN;
      end else if (smp_vld_w[ch]) begin
        avg_ff   <= nxt_avg;
        gain_ff  <= nxt_gain;
        tmr_ff   <= nxt_tmr;
        deb_ff   <= nxt_deb;
        phase_ff <= !phase_ff;
        sat_ff   <= (smp_w[ch] == ragc_pkg::FULL_POS) | (smp_w[ch] == ragc_pkg::FULL_NEG);
        mute_ff  <= mute_w[ch];
        gate_ff  <= nxt_gate;
      end
    end

    assign gain_w[ch]    = gain_ff;
    assign pmute_w[ch]   = mute_ff;
    assign gate_w[ch]    = gated_w;
    assign sat_w[ch]     = sat_ff;
  end

endmodule : ragc_record_agc

`default_nettype wire

//--- ragc_monitor.sv
// assertion checker on the ports of the record-path gain control
`timescale 1ns/10ps
`default_nettype none
module ragc_monitor (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic [15:0] adc_sample_left_i,
  input wire logic        adc_sample_valid_left_i,
  input wire logic        adc_sample_valid_right_i,
  input wire logic        agc_enable_left_i,
  input wire logic [6:0]  max_gain_left_i,
  input wire logic [6:0]  manual_gain_left_i,
  input wire logic        mute_left_i,
  input wire logic        step_slow_left_i,
  input wire logic [6:0]  pga_gain_left_o,
  input wire logic        pga_mute_left_o,
  input wire logic        noise_gate_flag_left_o,
  input wire logic        saturation_flag_left_o,
  input wire logic [6:0]  pga_gain_right_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic stb = adc_sample_valid_left_i;
  wire logic [6:0] gain = pga_gain_left_o;
  ////////////////////////////////////////////////////////////////////////
  a_gain_held: assert property (!stb |=> $stable(gain))
    else $error("left gain moved between samples");
  a_right_held: assert property (!adc_sample_valid_right_i |=> $stable(pga_gain_right_o))
    else $error("right gain moved without a right sample");
  // difference of -1, 0 or +1 maps onto 0..2 after the offset
  a_single_step: assert property (stb |=> 8'(gain) + 8'h01 - 8'($past(gain)) <= 8'h02)
    else $error("gain moved more than one step");
  a_sat_match: assert property (stb |=> saturation_flag_left_o ==
    $past(adc_sample_left_i == ragc_pkg::FULL_POS || adc_sample_left_i == ragc_pkg::FULL_NEG))
    else $error("saturation flag wrong");
  a_mute_copy: assert property (stb |=> pga_mute_left_o == $past(mute_left_i))
    else $error("mute not copied at sample");
  a_manual_up: assert property (stb && !agc_enable_left_i && !step_slow_left_i
    && gain < manual_gain_left_i && gain < 7'h77 |=> gain == $past(gain) + 7'h01)
    else $error("manual gain not approached");
  a_ceiling_down: assert property (stb && agc_enable_left_i && !step_slow_left_i
    && gain > max_gain_left_i |=> gain == $past(gain) - 7'h01)
    else $error("gain above ceiling not lowered");
  a_gated_ramp: assert property (stb && noise_gate_flag_left_o && agc_enable_left_i && gain != 7'h00
    |=> !noise_gate_flag_left_o || gain == $past(gain) - 7'h01)
    else $error("gated gain not ramping down");
  a_gated_no_rise: assert property (noise_gate_flag_left_o [*2] |-> gain <= $past(gain))
    else $error("gain rose while gated");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  c_gated: cover property (stb && noise_gate_flag_left_o);
  c_sat: cover property (stb && saturation_flag_left_o);
  c_ceiling: cover property (stb && agc_enable_left_i && gain > max_gain_left_i);
endmodule : ragc_monitor
`default_nettype wire

//--- ragc_pga_model.sv
// behavioural amplifier plus decimator feeding one converter channel
`timescale 1ns/10ps
`default_nettype none
module ragc_pga_model #(
  parameter int PERIOD = 4
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] level_i,
  input  wire logic        mute_i,
  output var  logic [15:0] sample_o,
  output var  logic        valid_o
);
  int   cnt;
  logic neg;
  // one strobe every PERIOD clocks stands in for the reference sample rate
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 0;
      neg <= 1'b0;
      valid_o <= 1'b0;
      sample_o <= 16'h0000;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      valid_o <= (cnt == PERIOD - 1);
      if (cnt == PERIOD - 1) begin
        neg <= ~neg;
        // a muted amplifier hands the converter silence; sign alternates like audio
        sample_o <= mute_i ? 16'h0000 : (neg ? 16'h0000 - level_i : level_i);
      end
    end
  end
endmodule : ragc_pga_model
`default_nettype wire

//--- test_ragc_record_agc.sv
// self-checking bench for the record-path gain control
`timescale 1ns/10ps
`default_nettype none
module test_ragc_record_agc;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [6:0]  reg_addr_i = 7'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic [7:0]  reg_rdata_o;
  logic [15:0] adc_sample_left_i, adc_sample_right_i, level_l = 16'h0000;
  logic        adc_sample_valid_left_i, adc_sample_valid_right_i;
  logic        agc_enable_left_i = 1'b0, noise_gate_enable_left_i = 1'b0;
  logic        mute_left_i = 1'b0, step_slow_left_i = 1'b0;
  logic [2:0]  target_sel_left_i = 3'h7;
  logic [3:0]  noise_thr_sel_left_i = 4'h0;
  logic [1:0]  hysteresis_sel_left_i = 2'h0;
  logic [7:0]  debounce_len_left_i = 8'h00;
  logic [6:0]  max_gain_left_i = 7'h14, manual_gain_left_i = 7'h00, manual_gain_right_i = 7'h03;
  // right shares the left settings except manual gain, and sees its own quiet source and registers
  wire logic       agc_enable_right_i = agc_enable_left_i, noise_gate_enable_right_i = noise_gate_enable_left_i;
  wire logic       mute_right_i = mute_left_i, step_slow_right_i = step_slow_left_i;
  wire logic [2:0] target_sel_right_i = target_sel_left_i;
  wire logic [3:0] noise_thr_sel_right_i = noise_thr_sel_left_i;
  wire logic [1:0] hysteresis_sel_right_i = hysteresis_sel_left_i;
  wire logic [7:0] debounce_len_right_i = debounce_len_left_i;
  wire logic [6:0] max_gain_right_i = max_gain_left_i;
  logic [6:0]  pga_gain_left_o, pga_gain_right_o;
  logic        pga_mute_left_o, pga_mute_right_o, noise_gate_flag_left_o, noise_gate_flag_right_o;
  logic        saturation_flag_left_o, saturation_flag_right_o;
  int          err_count = 0, num_checks = 0, cycles = 0;

  ragc_record_agc dut_u (.*);
  ragc_pga_model pm_l (.clk_i(ref_clk_i), .reset_n_i(reset_n_i), .level_i(level_l), .mute_i(pga_mute_left_o),
    .sample_o(adc_sample_left_i), .valid_o(adc_sample_valid_left_i));
  ragc_pga_model pm_r (.clk_i(ref_clk_i), .reset_n_i(reset_n_i), .level_i(16'h0100), .mute_i(pga_mute_right_o),
    .sample_o(adc_sample_right_i), .valid_o(adc_sample_valid_right_i));

  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : reg_wr

  task automatic reg_chk(input logic [6:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    chk("register", 16'(exp), 16'(reg_rdata_o));
    @(negedge ref_clk_i);
  endtask : reg_chk

  // returns at the falling edge after the n-th left sample was taken
  task automatic strobes(input int n);
    repeat (n) @(posedge ref_clk_i iff adc_sample_valid_left_i);
    @(negedge ref_clk_i);
  endtask : strobes

  task automatic gain_is(input logic [6:0] g);
    chk("left gain", 16'(g), 16'(pga_gain_left_o));
  endtask : gain_is
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      reg_chk(7'h67 + 7'(i), 8'h00);
      reg_wr(7'h67 + 7'(i), 8'hA0 + 8'(i));
    end
    reg_wr(7'h6B, 8'h55);
    reg_chk(7'h6B, 8'h00);
    for (int i = 0; i < 4; i++) begin
      reg_chk(7'h67 + 7'(i), 8'hA0 + 8'(i));
    end
    // slow right settings prove the left timing reads only its own registers
    reg_wr(7'h67, 8'hFF);
    reg_wr(7'h68, 8'hFF);
    reg_wr(7'h69, 8'h00);
    reg_wr(7'h6A, 8'h00);
  endtask : t_regs

  task automatic t_manual();
    manual_gain_left_i = 7'h0A;
    strobes(5);
    gain_is(7'h05);
    strobes(7);
    gain_is(7'h0A);
    chk("right gain", 16'h0003, 16'(pga_gain_right_o));
    chk("left mute", 16'h0000, 16'(pga_mute_left_o));
    mute_left_i = 1'b1;
    strobes(1);
    chk("left mute", 16'h0001, 16'(pga_mute_left_o));
    chk("right mute", 16'h0001, 16'(pga_mute_right_o));
    mute_left_i = 1'b0;
    step_slow_left_i = 1'b1;
    manual_gain_left_i = 7'h00;
    strobes(4);
    gain_is(7'h08);
    step_slow_left_i = 1'b0;
  endtask : t_manual

  task automatic t_sat();
    level_l = 16'h7FFF;
    repeat (2) begin
      strobes(1);
      chk("saturation", 16'(adc_sample_left_i === 16'h7FFF), 16'(saturation_flag_left_o));
    end
    chk("right saturation", 16'h0000, 16'(saturation_flag_right_o));
    chk("gate open", 16'h0000, 16'(noise_gate_flag_left_o));
  endtask : t_sat

  task automatic t_ceiling();
    manual_gain_left_i = 7'h08;
    level_l = 16'h0100;
    max_gain_left_i = 7'h03;
    agc_enable_left_i = 1'b1;
    strobes(5);
    gain_is(7'h03);
    strobes(3);
    gain_is(7'h03);
    chk("gate off", 16'h0000, 16'(noise_gate_flag_left_o));
  endtask : t_ceiling

  task automatic t_gate();
    agc_enable_left_i = 1'b0;
    manual_gain_left_i = 7'h0C;
    max_gain_left_i = 7'h14;
    level_l = 16'h0010;
    strobes(9);
    gain_is(7'h0C);
    noise_gate_enable_left_i = 1'b1;
    agc_enable_left_i = 1'b1;
    strobes(14);
    gain_is(7'h00);
    chk("gate flag", 16'h0001, 16'(noise_gate_flag_left_o));
    hysteresis_sel_left_i = 2'h1;
    debounce_len_left_i = 8'h02;
    strobes(10);
    gain_is(7'h00);
    level_l = 16'h4000;
    strobes(30);
    chk("gate flag", 16'h0000, 16'(noise_gate_flag_left_o));
    chk("right gate", 16'h0001, 16'(noise_gate_flag_right_o));
  endtask : t_gate

  task automatic t_attack();
    agc_enable_left_i = 1'b0;
    noise_gate_enable_left_i = 1'b0;
    manual_gain_left_i = 7'h05;
    strobes(8);
    gain_is(7'h05);
    agc_enable_left_i = 1'b1;
    strobes(330);
    gain_is(7'h05);
    strobes(20);
    gain_is(7'h04);
  endtask : t_attack

  task automatic t_decay();
    agc_enable_left_i = 1'b0;
    manual_gain_left_i = 7'h04;
    level_l = 16'h0100;
    strobes(400);
    agc_enable_left_i = 1'b1;
    strobes(2390);
    gain_is(7'h04);
    strobes(30);
    gain_is(7'h05);
  endtask : t_decay

  initial begin
    repeat (10) @(negedge ref_clk_i);
    gain_is(7'h00);
    chk("mute in reset", 16'h0001, 16'(pga_mute_left_o));
    reset_n_i = 1'b1;
    @(negedge ref_clk_i);
    t_regs();
    t_manual();
    t_sat();
    t_ceiling();
    t_gate();
    t_attack();
    t_decay();
    conclude();
  end
endmodule : test_ragc_record_agc

bind ragc_record_agc ragc_monitor mon_u (.ref_clk_i, .reset_n_i, .reg_rd_i, .reg_rdata_o, .adc_sample_left_i,
  .adc_sample_valid_left_i, .adc_sample_valid_right_i, .agc_enable_left_i, .max_gain_left_i, .manual_gain_left_i,
  .mute_left_i, .step_slow_left_i, .pga_gain_left_o, .pga_mute_left_o, .noise_gate_flag_left_o,
  .saturation_flag_left_o, .pga_gain_right_o);
`default_nettype wire
